// ### tcs_pkg.sv
// Package with constants and types for the timer count source and sync block.
package tcs_pkg;

  localparam int unsigned NCH     = 3;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned PRE_W   = 10;

  // Register byte offsets; each group holds one word per channel.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CNT   = 8'h10;
  localparam logic [7:0] OFS_CMP_A = 8'h20;
  localparam logic [7:0] OFS_CMP_B = 8'h30;

  // Address field positions used by the decoder.
  localparam int unsigned ADR_GRP_HI = 5;
  localparam int unsigned ADR_GRP_LO = 4;
  localparam int unsigned ADR_CH_HI  = 3;
  localparam int unsigned ADR_CH_LO  = 2;
  localparam logic [1:0]  GRP_CTRL   = OFS_CTRL[5:4];
  localparam logic [1:0]  GRP_CNT    = OFS_CNT[5:4];
  localparam logic [1:0]  GRP_CMP_A  = OFS_CMP_A[5:4];
  localparam logic [1:0]  GRP_CMP_B  = OFS_CMP_B[5:4];
  localparam logic [1:0]  LAST_CH    = 2'h2;

  // Count source codes.
  localparam logic [2:0] SRC_DIV1  = 3'h0;
  localparam logic [2:0] SRC_DIV4  = 3'h1;
  localparam logic [2:0] SRC_DIV16 = 3'h2;
  localparam logic [2:0] SRC_DIV64 = 3'h3;
  localparam logic [2:0] SRC_PIN_A = 3'h4;
  localparam logic [2:0] SRC_PIN_B = 3'h5;
  localparam logic [2:0] SRC_CODE6 = 3'h6;
  localparam logic [2:0] SRC_CODE7 = 3'h7;

  // Reset values.
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // Channel control word, low bits of the control register.
  typedef struct packed {
    logic       pwm_mode;
    logic       clear_en;
    logic       sync_en;
    logic       phase_mode;
    logic [2:0] src;
  } tcs_ctrl_s;

  localparam int unsigned CTRL_W   = 7;
  localparam tcs_ctrl_s   CTRL_RST = 7'h00;

endpackage

// ### tcs_timer.sv
// Three timer channels with count source selection and synchronous operation.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns

// Notes on behaviour
// - Channel 0 codes 0-3 divide pclk by 1, 4, 16, 64; 4-7 pick pins A-D.
// - Every count source field resets to code 0, the undivided clock.
// - Channel 1 codes 0-5 match channel 0 and code 6 divides pclk by 256.
// - Channel 1 code 7 cascades on channel 2 overflow and underflow.
// - Channel 2 codes 0-6 pick dividers then pins A-C; 7 divides by 1024.
// - Channels 1 and 2 in phase mode ignore the source and use phase pins.
// - Synced channels 1 and 2 with clear_en set also clear on the channel 0 compare B clear if channel 0 is synced too.
// - A preset of one synced counter loads every synced counter at once.
// - Synced PWM channels drive three-phase PWM, period set by compare 0B.
// - Counters go down only in phase or cascade mode, else up only.
// - Reset zeroes each counter and sets each compare register to ones.
module tcs_timer
  import tcs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clock_pin_a,
  input  wire logic        ext_clock_pin_b,
  input  wire logic        ext_clock_pin_c,
  input  wire logic        ext_clock_pin_d,
  output logic             channel0_output_a,
  output logic             channel1_output_a,
  output logic             channel2_output_a
);

  tcs_ctrl_s        ctrl                 [NCH];
  logic [CNT_W-1:0] channel_counter      [NCH];
  logic [CNT_W-1:0] general_compare_reg_a[NCH];
  logic [CNT_W-1:0] general_compare_reg_b[NCH];
  logic [PRE_W-1:0] prescale;
  logic [3:0]       pin_meta;
  logic [3:0]       pin_sync;
  logic [3:0]       pin_prev;
  logic [NCH-1:0]   pwm_out;
  logic [NCH-1:0]   inc;
  logic [NCH-1:0]   dec;
  logic [NCH-1:0]   load;
  logic [NCH-1:0]   clr;
  logic [NCH-1:0]   cnt_hit;
  logic [NCH-1:0]   ph_up;
  logic [NCH-1:0]   ph_dn;
  logic [7:0]       src_vec [NCH];
  logic [CNT_W-1:0] channel2_counter;

  // APB decode.
  wire [1:0] adr_grp  = paddr[ADR_GRP_HI:ADR_GRP_LO];
  wire [1:0] adr_ch   = paddr[ADR_CH_HI:ADR_CH_LO];
  wire       adr_ok   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                        (adr_ch <= LAST_CH);
  wire       acc      = psel && penable;
  wire       wr_en    = acc && pwrite && adr_ok;
  wire       rd_setup = psel && !penable && !pwrite;

  assign pready  = 1'b1;
  assign pslverr = acc && !adr_ok;

  // Prescaler taps; a tap is high for one cycle per divided period.
  wire div4    = &prescale[1:0];
  wire div16   = &prescale[3:0];
  wire div64   = &prescale[5:0];
  wire div256  = &prescale[7:0];
  wire div1024 = &prescale[9:0];

  // Synchronised pin edges; pin_meta is read only by pin_sync.
  wire [3:0] pin_rise = pin_sync & ~pin_prev;
  wire [3:0] pin_fall = ~pin_sync & pin_prev;
  wire [3:0] pin_chg  = pin_rise | pin_fall;

  assign channel2_counter = channel_counter[2];
  wire casc_up = inc[2] && (channel2_counter == CNT_MAX);
  wire casc_dn = dec[2] && (channel2_counter == CNT_RST);

  // Channel 0 compare B clear, shared with synchronous-clear channels.
  wire clr0_ev = ctrl[0].clear_en && inc[0] &&
                 (channel_counter[0] == general_compare_reg_b[0]);
  wire sync_wr = |(cnt_hit & {ctrl[2].sync_en, ctrl[1].sync_en,
                              ctrl[0].sync_en});

  assign src_vec[0] = {pin_rise[3], pin_rise[2], pin_rise[1], pin_rise[0],
                       div64, div16, div4, 1'b1};
  assign src_vec[1] = {casc_up, div256, pin_rise[1], pin_rise[0],
                       div64, div16, div4, 1'b1};
  assign src_vec[2] = {div1024, pin_rise[2], pin_rise[1], pin_rise[0],
                       div64, div16, div4, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
    end else begin
      prescale <= PRE_W'(prescale + 1'b1);
      pin_meta <= {ext_clock_pin_d, ext_clock_pin_c,
                   ext_clock_pin_b, ext_clock_pin_a};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      localparam logic [1:0] CH = 2'(i);
      // Phase pins: A and B for channel 1, C and D for channel 2.
      localparam int unsigned PA = (i == 2) ? 2 : 0;
      logic [CNT_W-1:0] next_cnt;
      wire a_lvl = pin_sync[PA];
      wire b_lvl = pin_sync[PA+1];
      wire a_chg = pin_chg[PA];
      wire b_chg = pin_chg[PA+1];
      wire cascade = (i == 1) && (ctrl[i].src == SRC_CODE7);

      // Quadrature decode: A leading B counts up, B leading A counts down.
      assign ph_up[i] = (a_chg && (a_lvl != b_lvl)) ||
                        (b_chg && (a_lvl == b_lvl));
      assign ph_dn[i] = (a_chg && (a_lvl == b_lvl)) ||
                        (b_chg && (a_lvl != b_lvl));

      if (i == 0) begin : g_ch0
        assign inc[i] = src_vec[i][ctrl[i].src];
        assign dec[i] = 1'b0;
        assign clr[i] = clr0_ev;
      end else begin : g_chn
        wire phase = ctrl[i].phase_mode;
        assign inc[i] = phase ? ph_up[i] :
                        src_vec[i][ctrl[i].src];
        assign dec[i] = phase ? ph_dn[i] :
                        (cascade && casc_dn);
        assign clr[i] = clr0_ev && ctrl[0].sync_en && ctrl[i].sync_en &&
                        ctrl[i].clear_en;
      end

      assign cnt_hit[i] = wr_en && (adr_grp == GRP_CNT) && (adr_ch == CH);
      assign load[i] = cnt_hit[i] || (ctrl[i].sync_en && sync_wr);

      always_comb begin
        next_cnt = channel_counter[i];
        if (load[i]) begin
          next_cnt = pwdata[CNT_W-1:0];
        end else if (clr[i]) begin
          next_cnt = CNT_RST;
        end else if (inc[i]) begin
          next_cnt = CNT_W'(channel_counter[i] + CNT_ONE);
        end else if (dec[i]) begin
          next_cnt = CNT_W'(channel_counter[i] - CNT_ONE);
        end
      end

      wire wr_ctrl  = wr_en && (adr_grp == GRP_CTRL)  && (adr_ch == CH);
      wire wr_cmp_a = wr_en && (adr_grp == GRP_CMP_A) && (adr_ch == CH);
      wire wr_cmp_b = wr_en && (adr_grp == GRP_CMP_B) && (adr_ch == CH);
      wire a_match  = inc[i] && (next_cnt == general_compare_reg_a[i]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[i]                  <= CTRL_RST;
          channel_counter[i]       <= CNT_RST;
          general_compare_reg_a[i] <= CMP_RST;
          general_compare_reg_b[i] <= CMP_RST;
          pwm_out[i]               <= 1'b0;
        end else begin
          channel_counter[i] <= next_cnt;
          if (wr_ctrl) begin
            ctrl[i] <= tcs_ctrl_s'(pwdata[CTRL_W-1:0]);
          end
          if (wr_cmp_a) begin
            general_compare_reg_a[i] <= pwdata[CNT_W-1:0];
          end
          if (wr_cmp_b) begin
            general_compare_reg_b[i] <= pwdata[CNT_W-1:0];
          end
          // Low from each period start, high from the A match on.
          if (!ctrl[i].pwm_mode || clr[i] || load[i]) begin
            pwm_out[i] <= 1'b0;
          end else if (a_match) begin
            pwm_out[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  assign channel0_output_a = pwm_out[0];
  assign channel1_output_a = pwm_out[1];
  assign channel2_output_a = pwm_out[2];

  // Read data is captured in the setup cycle so that it comes from a flop.
  // Limitation: a counter read shows its value one cycle before the edge.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_ok) begin
      unique case (adr_grp)
        GRP_CTRL:  rd_mux = {25'h0, ctrl[adr_ch]};
        GRP_CNT:   rd_mux = {16'h0, channel_counter[adr_ch]};
        GRP_CMP_A: rd_mux = {16'h0, general_compare_reg_a[adr_ch]};
        GRP_CMP_B: rd_mux = {16'h0, general_compare_reg_b[adr_ch]};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Helper flags for checks that hold until software first writes.
  logic ctrl_touched;
  logic cmp_touched;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_touched <= 1'b0;
      cmp_touched  <= 1'b0;
    end else begin
      ctrl_touched <= ctrl_touched || (wr_en && adr_grp == GRP_CTRL);
      cmp_touched  <= cmp_touched  || (wr_en && adr_grp[1]);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire q0 = !load[0] && !clr[0];
  wire q1 = !load[1] && !clr[1];
  wire q2 = !load[2] && !clr[2];

  sequence s_period_start;
    ctrl[0].pwm_mode && clr[0] && !load[0];
  endsequence
  sequence s_out_low_then;
    !channel0_output_a ##0 (channel_counter[0] == CNT_RST);
  endsequence

  src_reset_a: assert property (!ctrl_touched |->
    ctrl[0].src == SRC_DIV1 && ctrl[1].src == SRC_DIV1 &&
    ctrl[2].src == SRC_DIV1) else $error("count source not reset");

  div4_hold_a: assert property (
    ctrl[0].src == SRC_DIV4 && q0 && prescale[1:0] != 2'h3
    |=> $stable(channel_counter[0])) else $error("div4 counted early");

  div256_step_a: assert property (
    !ctrl[1].phase_mode && ctrl[1].src == SRC_CODE6 && q1 &&
    prescale[7:0] == 8'hFF |=> channel_counter[1] ==
    $past(channel_counter[1]) + CNT_ONE) else $error("div256 missed");

  cascade_up_a: assert property (
    !ctrl[1].phase_mode && ctrl[1].src == SRC_CODE7 && q1 && casc_up
    |=> channel_counter[1] == $past(channel_counter[1]) + CNT_ONE)
    else $error("cascade overflow not counted");

  div1024_hold_a: assert property (
    !ctrl[2].phase_mode && ctrl[2].src == SRC_CODE7 && q2 &&
    prescale != 10'h3FF |=> $stable(channel_counter[2]))
    else $error("div1024 counted early");

  phase_ignore_a: assert property (
    ctrl[1].phase_mode && q1 && !ph_up[1] && !ph_dn[1]
    |=> $stable(channel_counter[1])) else $error("phase mode used source");

  sync_clear_a: assert property (
    clr0_ev && ctrl[0].sync_en && ctrl[2].sync_en && ctrl[2].clear_en &&
    !load[2] |=> channel_counter[2] == CNT_RST)
    else $error("sync clear missed");

  sync_preset_a: assert property (
    cnt_hit[1] && ctrl[0].sync_en && ctrl[1].sync_en
    |=> channel_counter[0] == channel_counter[1] &&
        channel_counter[0] == $past(pwdata[CNT_W-1:0]))
    else $error("sync preset not common");

  pwm_period_a: assert property (s_period_start |=> s_out_low_then)
    else $error("pwm period start wrong");

  ch0_up_only_a: assert property (q0 |=>
    channel_counter[0] == $past(channel_counter[0]) ||
    channel_counter[0] == $past(channel_counter[0]) + CNT_ONE)
    else $error("channel 0 counted down");

  cmp_reset_a: assert property (!cmp_touched |->
    general_compare_reg_b[0] == CMP_RST &&
    general_compare_reg_a[2] == CMP_RST) else $error("compare not ones");

  pin_edge_a: assert property (
    ctrl[0].src == SRC_PIN_A && q0 && $rose(ext_clock_pin_a)
    ##2 q0 |=> channel_counter[0] == $past(channel_counter[0]) + CNT_ONE)
    else $error("pin edge not counted once");

endmodule

// ### tcs_ext_src.sv
// Model of the external clock sources that drive the timer pins.
`timescale 1ns/1ns
module tcs_ext_src (
  input  wire logic pclk,
  output logic      ext_clock_pin_a,
  output logic      ext_clock_pin_b,
  output logic      ext_clock_pin_c,
  output logic      ext_clock_pin_d
);
  logic [3:0] lvl;
  assign ext_clock_pin_a = lvl[0];
  assign ext_clock_pin_b = lvl[1];
  assign ext_clock_pin_c = lvl[2];
  assign ext_clock_pin_d = lvl[3];
  initial lvl = 4'h0;
  // Levels last several edges, so the synchroniser cannot miss a pulse.
  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      lvl[idx] <= 1'b1;
      repeat (3) @(posedge pclk);
      lvl[idx] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic step(input int idx);
    @(posedge pclk);
    lvl[idx] <= ~lvl[idx];
    repeat (3) @(posedge pclk);
  endtask
endmodule

// ### timer_clock_select_sync_tb_top.sv
// Self-checking bench for the timer count source and sync block.
`timescale 1ns/1ns
module timer_clock_select_sync_tb_top;
  import tcs_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin;
  logic [2:0]  pwm;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          n_compared;

  tcs_timer tcs_timer_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin_a(pin[0]), .ext_clock_pin_b(pin[1]),
    .ext_clock_pin_c(pin[2]), .ext_clock_pin_d(pin[3]),
    .channel0_output_a(pwm[0]), .channel1_output_a(pwm[1]),
    .channel2_output_a(pwm[2]));
  tcs_ext_src tcs_ext_src_inst (
    .pclk(pclk), .ext_clock_pin_a(pin[0]), .ext_clock_pin_b(pin[1]),
    .ext_clock_pin_c(pin[2]), .ext_clock_pin_d(pin[3]));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  function automatic logic [7:0] ra(input logic [7:0] b, input int c);
    return b + 8'(4 * c);
  endfunction

  // Zero wait states are expected, but the loop still bounds a stuck bus.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      $display("BAD %0t bus hang", $time);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    apb(1'b0, ra(OFS_CNT, 0), 32'h0);
    // Cleared at reset, then one count at the first edge after release.
    cmp(rd[15:0], 16'h0001, "counter reset");
    for (int c = 0; c < 3; c++) begin
      apb(1'b0, ra(OFS_CTRL, c), 32'h0);
      cmp(rd[15:0], 16'h0000, "ctrl reset");
      apb(1'b0, ra(OFS_CMP_A, c), 32'h0);
      cmp(rd[15:0], CMP_RST, "cmp a reset");
      apb(1'b0, ra(OFS_CMP_B, c), 32'h0);
      cmp(rd[15:0], CMP_RST, "cmp b reset");
    end
    apb(1'b0, 8'h0C, 32'h0);
    cmp(16'(err), 16'h0001, "unmapped error");
    cmp(rd[15:0], 16'h0000, "unmapped data");
    $display("reset test done");
  endtask

  function automatic int src_div(input int c, input int s);
    if (s < 4) return 4 ** s;
    if (c == 1 && s == 6) return 256;
    if (c == 2 && s == 7) return 1024;
    if (c == 1 && s == 7) return 0;
    return -1;
  endfunction

  // Prescaler phase is free running, so a window one cycle short of eight
  // ticks may hold one tick fewer; a wrong divider is off by a factor of four or more.
  task automatic t_src();
    int dv;
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 8; s++) begin
        dv = src_div(c, s);
        if (dv != 0) begin
          apb(1'b1, ra(OFS_CTRL, c), 32'(s));
          apb(1'b1, ra(OFS_CNT, c), 32'h0);
          if (dv > 0) begin
            repeat (8 * dv - 2) @(posedge pclk);
            apb(1'b0, ra(OFS_CNT, c), 32'h0);
            n_compared++;
            if ((rd[15:0] >= 7 && rd[15:0] <= 9) !== 1'b1) begin
              fails++;
              $display("BAD %0t divider ch %0d code %0d", $time, c, s);
            end
          end else begin
            tcs_ext_src_inst.pulse(s - 4, 5);
            repeat (6) @(posedge pclk);
            apb(1'b0, ra(OFS_CNT, c), 32'h0);
            cmp(rd[15:0], 16'h0005, "pin count");
          end
        end
      end
    end
    $display("source test done");
  endtask

  task automatic t_cascade();
    apb(1'b1, ra(OFS_CTRL, 2), 32'h0);
    apb(1'b1, ra(OFS_CTRL, 1), 32'h7);
    apb(1'b1, ra(OFS_CNT, 1), 32'h0);
    apb(1'b1, ra(OFS_CNT, 2), 32'hFFF0);
    repeat (40) @(posedge pclk);
    apb(1'b0, ra(OFS_CNT, 1), 32'h0);
    cmp(rd[15:0], 16'h0001, "cascade up");
    apb(1'b1, ra(OFS_CTRL, 2), 32'h8);
    apb(1'b1, ra(OFS_CNT, 2), 32'h0);
    tcs_ext_src_inst.step(3);
    repeat (6) @(posedge pclk);
    apb(1'b0, ra(OFS_CNT, 2), 32'h0);
    cmp(rd[15:0], 16'hFFFF, "phase down");
    apb(1'b0, ra(OFS_CNT, 1), 32'h0);
    cmp(rd[15:0], 16'h0000, "cascade down");
    apb(1'b1, ra(OFS_CTRL, 1), 32'h8);
    apb(1'b1, ra(OFS_CNT, 1), 32'h0);
    tcs_ext_src_inst.step(0);
    repeat (6) @(posedge pclk);
    apb(1'b0, ra(OFS_CNT, 1), 32'h0);
    cmp(rd[15:0], 16'h0001, "phase up");
    $display("cascade test done");
  endtask

  task automatic t_sync();
    int          hi [3];
    logic [15:0] a;
    hi = '{0, 0, 0};
    apb(1'b1, ra(OFS_CMP_B, 0), 32'h9);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, ra(OFS_CMP_A, c), 32'(3 + 2 * c));
      apb(1'b1, ra(OFS_CTRL, c), 32'h70);
    end
    apb(1'b1, ra(OFS_CNT, 1), 32'h0);
    apb(1'b0, ra(OFS_CNT, 0), 32'h0);
    a = rd[15:0];
    cmp(a, 16'h0001, "sync preset ch0");
    apb(1'b0, ra(OFS_CNT, 2), 32'h0);
    cmp(rd[15:0], (a + 16'h0003) % 16'h000A, "sync");
    repeat (20) @(posedge pclk);
    for (int k = 0; k < 40; k++) begin
      @(posedge pclk);
      for (int c = 0; c < 3; c++) hi[c] += int'(pwm[c] === 1'b1);
    end
    for (int c = 0; c < 3; c++) begin
      cmp(16'(hi[c]), 16'(4 * (7 - 2 * c)), "pwm duty");
    end
    $display("sync test done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_src();
    t_cascade();
    t_sync();
    close_out();
  end
endmodule
